// File: src/css_pkg.sv
// shared constants and carrier types for the converter sample scheduler
package css_pkg;
  // clock and cycle timing
  localparam int CLK_MHZ    = 200;
  localparam int CYCLE_NS   = 4000;
  localparam int CYCLE_CLKS = CYCLE_NS * CLK_MHZ / 1000;
  localparam int CNT_W      = 10;
  localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_CLKS - 1);

  // converter word and serial rates
  localparam int SAMPLE_W = 16;
  localparam int BITS_W   = 6;
  localparam logic [BITS_W-1:0] RX_BITS = BITS_W'(SAMPLE_W);
  localparam logic [BITS_W-1:0] TX_BITS = BITS_W'(2 * SAMPLE_W);
  localparam logic [CNT_W-1:0] RX_DIV  = 10'h028;
  localparam logic [CNT_W-1:0] TX_DIV  = RX_DIV >> 1;

  // rotating selectors
  localparam int AUX_INPUTS = 4;
  localparam int AUX_SEL_W  = 2;
  localparam int SLOW_OUTS  = 8;
  localparam int SLOW_SEL_W = 3;
  localparam logic [SLOW_SEL_W-1:0] SLOW_SEL_LAST = SLOW_SEL_W'(SLOW_OUTS - 1);
  localparam logic [AUX_SEL_W-1:0]  AUX_SEL_LAST  = AUX_SEL_W'(AUX_INPUTS - 1);

  // processor instruction slots per cycle
  localparam int INSTR_PER_CYCLE = 59;
  localparam logic [CNT_W-1:0] INSTR_CLKS  = CNT_W'(CYCLE_CLKS / INSTR_PER_CYCLE);
  localparam logic [BITS_W:0]  INSTR_COUNT = 7'(INSTR_PER_CYCLE);

  // synthesis phase accumulator
  localparam int PHASE_W = 32;
  localparam logic [PHASE_W-1:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [15:0] SINE_QUARTER [16] = '{
    16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f, 16'h36ba, 16'h41ce, 16'h4c3c, 16'h55f6,
    16'h5ed9, 16'h66cf, 16'h6dc9, 16'h73b6, 16'h7885, 16'h7c29, 16'h7e9d, 16'h7fd8};

  // host bus decode map
  localparam int ADDR_W = 4;
  localparam int CS_W   = 8;
  localparam logic [ADDR_W-1:0] ADDR_CFG0    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG1    = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_LO = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_HI = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_ANA0    = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_ANA1    = 4'h5;
  localparam logic [SAMPLE_W-1:0] CFG_RESET  = 16'h0000;

  typedef struct packed {
    logic                cs_n;
    logic                wr_n;
    logic [ADDR_W-1:0]   addr;
    logic [SAMPLE_W-1:0] data;
  } css_host_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
  } css_iq_t;
endpackage

// File: src/css_shift.sv
// loadable shift register used for serial-to-parallel and parallel-to-serial paths
`timescale 1ns/10ps
module css_shift #(
  parameter int W = 16
) (
  input  wire logic         clk_in,    // system clock
  input  wire logic         rst_in,    // synchronous reset
  input  wire logic         load_in,   // parallel load
  input  wire logic [W-1:0] value_in,  // parallel load word
  input  wire logic         shift_in,  // shift one bit, msb first
  input  wire logic         ser_in,    // serial bit entering lsb
  output logic      [W-1:0] par_out    // register contents, msb is serial out
);
  // load wins over shift
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      par_out <= '0;
    end else if (load_in) begin
      par_out <= value_in;
    end else if (shift_in) begin
      par_out <= {par_out[W-2:0], ser_in};
    end
  end
endmodule // css_shift

// File: src/css_sched.sv
// converter sample scheduler: frame timing, converter serial paths, synthesis and host decode
`timescale 1ns/10ps
module css_sched
  import css_pkg::*;
(
  input  wire logic                  clk_in,          // system clock
  input  wire logic                  rst_in,          // synchronous reset
  input  wire css_host_t             host_in,         // host bus pins
  input  wire logic                  adc_sig_in,      // signal channel serial data
  input  wire logic                  adc_aux_in,      // aux channel serial data
  input  wire css_iq_t               iq_in,           // in-phase and quadrature results
  input  wire logic [SAMPLE_W-1:0]   slow_val_in [SLOW_OUTS], // eight slow output values
  output logic                       adc_conv_out,    // sample both channels now
  output logic                       adc_sclk_out,    // receive bit clock
  output logic [AUX_SEL_W-1:0]       aux_sel_out,     // aux input being converted
  output logic [SAMPLE_W-1:0]        sig_sample_out,  // received signal sample
  output logic [SAMPLE_W-1:0]        aux_sample_out,  // received aux sample
  output logic [AUX_SEL_W-1:0]       aux_tag_out,     // aux input of aux_sample_out
  output logic                       sample_vld_out,  // both samples new, one pulse
  output logic                       tx_sclk_out,     // transmit bit clock
  output logic                       tx_data_out,     // transmit serial data
  output logic                       tx_frame_out,    // transmit word framing
  output logic                       p2s_sclk_out,    // parallel-to-serial bit clock
  output logic                       p2s_data_out,    // parallel-to-serial data
  output logic                       p2s_frame_out,   // parallel-to-serial framing
  output logic [SLOW_SEL_W-1:0]      slow_sel_out,    // slow output being refreshed
  output logic [SAMPLE_W-1:0]        sine_out,        // latest sine sample
  output logic                       instr_tick_out,  // instruction slot pulse
  output logic                       buf_en_out,      // host address and data buffers on
  output logic [CS_W-1:0]            cs_out,          // decoded chip selects
  output logic [SAMPLE_W-1:0]        cfg0_out,        // configuration latch 0
  output logic [SAMPLE_W-1:0]        cfg1_out,        // configuration latch 1
  output logic [SAMPLE_W-1:0]        iso_data_out,    // isolated analog bus data
  output logic                       iso_oe_out,      // isolated bus driven
  output logic [1:0]                 iso_stb_out      // analog latch load strobes
);
  // one-hot decode of a host address
  function automatic logic [CS_W-1:0] dec_addr(input logic [ADDR_W-1:0] a);
    dec_addr = '0;
    if (a < ADDR_W'(CS_W)) begin
      dec_addr[a[2:0]] = 1'b1;
    end
  endfunction

  function automatic logic is_analog(input logic [ADDR_W-1:0] a);
    is_analog = (a == ADDR_ANA0) || (a == ADDR_ANA1);
  endfunction

  // sine value from phase using quarter table
  function automatic logic [SAMPLE_W-1:0] sine_of(input logic [PHASE_W-1:0] ph);
    logic [3:0]          idx;
    logic [SAMPLE_W-1:0] mag;
    idx = ph[PHASE_W-3:PHASE_W-6];
    if (ph[PHASE_W-2]) begin
      idx = ~idx;
    end
    mag = SINE_QUARTER[idx];
    sine_of = ph[PHASE_W-1] ? SAMPLE_W'(-mag) : mag;
  endfunction

  logic [CNT_W-1:0]    tick;
  logic                frame;
  css_host_t           host_s1;
  css_host_t           host_s2;
  logic                sig_s1, sig_s2, aux_s1, aux_s2;
  logic [CNT_W-1:0]    rx_div, tx_div, ins_div;
  logic [BITS_W-1:0]   rx_bit, tx_bit;
  logic [BITS_W:0]     ins_cnt;
  logic                rx_shift, tx_shift; // last receive shift captures the sample words
  logic [2*SAMPLE_W-1:0] tx_word, p2s_word;
  logic [SAMPLE_W-1:0] sig_word, aux_word;
  logic [PHASE_W-1:0]  phase, freq;
  logic                wr_act, wr_prev, wr_edge;

  // cycle timer, one frame per cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick  <= '0;
      frame <= 1'b0;
    end else begin
      tick  <= (tick == CYCLE_LAST) ? '0 : tick + 1'b1;
      frame <= (tick == CYCLE_LAST);
    end
  end
  // two-stage synchronisers for the host bus and both converter serial data inputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_s1 <= '{cs_n: 1'b1, wr_n: 1'b1, addr: '0, data: '0};
      host_s2 <= '{cs_n: 1'b1, wr_n: 1'b1, addr: '0, data: '0};
      {sig_s1, sig_s2, aux_s1, aux_s2} <= '0;
    end else begin
      host_s1 <= host_in;
      host_s2 <= host_s1;
      sig_s1  <= adc_sig_in;
      sig_s2  <= sig_s1;
      aux_s1  <= adc_aux_in;
      aux_s2  <= aux_s1;
    end
  end
  // conversion start and rotating selectors
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_conv_out <= 1'b0;
      aux_sel_out  <= '0;
      slow_sel_out <= '0;
    end else begin
      adc_conv_out <= frame;
      if (frame) begin
        aux_sel_out  <= (aux_sel_out == AUX_SEL_LAST) ? '0 : aux_sel_out + 1'b1;
        slow_sel_out <= (slow_sel_out == SLOW_SEL_LAST) ? '0 : slow_sel_out + 1'b1;
      end
    end
  end
  // receive bit timing, data sampled at end of each bit
  always_ff @(posedge clk_in) begin
    if (rst_in || frame) begin
      rx_div <= '0;
      rx_bit <= rst_in ? RX_BITS : '0; // idle until the first frame
    end else if (rx_bit < RX_BITS) begin
      rx_div <= (rx_div == RX_DIV - 1'b1) ? '0 : rx_div + 1'b1;
      if (rx_div == RX_DIV - 1'b1) begin
        rx_bit <= rx_bit + 1'b1;
      end
    end
  end
  assign rx_shift = (rx_bit < RX_BITS) && (rx_div == RX_DIV - 1'b1);
  // serial-to-parallel for signal and aux streams
  css_shift #(.W(SAMPLE_W)) u_rx_sig (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (1'b0),
    .value_in ('0),
    .shift_in (rx_shift),
    .ser_in   (sig_s2),
    .par_out  (sig_word)
  );
  css_shift #(.W(SAMPLE_W)) u_rx_aux (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (1'b0),
    .value_in ('0),
    .shift_in (rx_shift),
    .ser_in   (aux_s2),
    .par_out  (aux_word)
  );
  // receive clock and completed sample capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_sclk_out   <= 1'b0;
      sig_sample_out <= '0;
      aux_sample_out <= '0;
      aux_tag_out    <= '0;
      sample_vld_out <= 1'b0;
    end else begin
      adc_sclk_out   <= (rx_bit < RX_BITS) && !frame && (rx_div < (RX_DIV >> 1));
      sample_vld_out <= 1'b0;
      if (rx_shift && rx_bit == RX_BITS - 1'b1) begin // once per frame, as the last bit enters
        sig_sample_out <= {sig_word[SAMPLE_W-2:0], sig_s2};
        aux_sample_out <= {aux_word[SAMPLE_W-2:0], aux_s2};
        aux_tag_out    <= aux_sel_out;
        sample_vld_out <= 1'b1;
      end
    end
  end
  // direct digital synthesis once per cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase    <= '0;
      sine_out <= '0;
    end else if (frame) begin
      phase    <= phase + freq;
      sine_out <= sine_of(phase + freq);
    end
  end
  // transmit timing at twice the receive bit rate
  always_ff @(posedge clk_in) begin
    if (rst_in || frame) begin
      tx_div <= '0;
      tx_bit <= rst_in ? TX_BITS : '0; // idle until the first frame
    end else if (tx_bit < TX_BITS) begin
      tx_div <= (tx_div == TX_DIV - 1'b1) ? '0 : tx_div + 1'b1;
      if (tx_div == TX_DIV - 1'b1) begin
        tx_bit <= tx_bit + 1'b1;
      end
    end
  end
  assign tx_shift = (tx_bit < TX_BITS) && (tx_div == TX_DIV - 1'b1);
  // serial port: sine then in-phase, one channel of each converter
  css_shift #(.W(2*SAMPLE_W)) u_tx (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (frame),
    .value_in ({sine_out, iq_in.x}),
    .shift_in (tx_shift),
    .ser_in   (1'b0),
    .par_out  (tx_word)
  );
  // parallel-to-serial: quadrature then current slow slot
  css_shift #(.W(2*SAMPLE_W)) u_p2s (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (frame),
    .value_in ({iq_in.y, slow_val_in[slow_sel_out]}),
    .shift_in (tx_shift),
    .ser_in   (1'b0),
    .par_out  (p2s_word)
  );
  // converter-side clocks, data and framing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {tx_sclk_out, tx_data_out, tx_frame_out}    <= '0;
      {p2s_sclk_out, p2s_data_out, p2s_frame_out} <= '0;
    end else begin
      tx_sclk_out   <= (tx_bit < TX_BITS) && !frame && (tx_div < (TX_DIV >> 1));
      tx_data_out   <= tx_word[2*SAMPLE_W-1];
      tx_frame_out  <= (tx_bit < TX_BITS) && !frame;
      p2s_sclk_out  <= (tx_bit < TX_BITS) && !frame && (tx_div < (TX_DIV >> 1));
      p2s_data_out  <= p2s_word[2*SAMPLE_W-1];
      p2s_frame_out <= (tx_bit < TX_BITS) && !frame;
    end
  end
  // instruction slot pacing within the cycle
  always_ff @(posedge clk_in) begin
    if (rst_in || frame) begin
      ins_div        <= '0;
      ins_cnt        <= '0;
      instr_tick_out <= 1'b0;
    end else begin
      instr_tick_out <= 1'b0;
      if (ins_cnt < INSTR_COUNT) begin
        ins_div <= (ins_div == INSTR_CLKS - 1'b1) ? '0 : ins_div + 1'b1;
        if (ins_div == INSTR_CLKS - 1'b1) begin
          ins_cnt        <= ins_cnt + 1'b1;
          instr_tick_out <= 1'b1;
        end
      end
    end
  end
  // host write detection
  assign wr_act  = !host_s2.cs_n && !host_s2.wr_n;
  assign wr_edge = wr_act && !wr_prev;
  // buffers, decoder, isolated analog bus and write edge history
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_prev      <= 1'b0;
      buf_en_out   <= 1'b0;
      cs_out       <= '0;
      iso_oe_out   <= 1'b0;
      iso_data_out <= '0;
      iso_stb_out  <= '0;
    end else begin
      wr_prev      <= wr_act;
      buf_en_out   <= wr_act;
      cs_out       <= wr_act ? dec_addr(host_s2.addr) : '0;
      iso_oe_out   <= wr_act && is_analog(host_s2.addr);
      iso_data_out <= (wr_act && is_analog(host_s2.addr)) ? host_s2.data : '0;
      iso_stb_out  <= wr_edge ? {host_s2.addr == ADDR_ANA1, host_s2.addr == ADDR_ANA0} : 2'h0;
    end
  end
  // edge-loaded configuration latches and frequency word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg0_out <= CFG_RESET;
      cfg1_out <= CFG_RESET;
      freq     <= FREQ_RESET;
    end else if (wr_edge) begin
      unique case (host_s2.addr)
        ADDR_CFG0:    cfg0_out <= host_s2.data;
        ADDR_CFG1:    cfg1_out <= host_s2.data;
        ADDR_FREQ_LO: freq[SAMPLE_W-1:0] <= host_s2.data;
        ADDR_FREQ_HI: freq[PHASE_W-1:SAMPLE_W] <= host_s2.data;
        default:      ;
      endcase
    end
  end
endmodule // css_sched

// File: verif/css_sched_monitor.sv
// port checker for the converter sample scheduler
`timescale 1ns/10ps
module css_sched_monitor
  import css_pkg::*;
(
  input wire logic                  clk_in,         // system clock
  input wire logic                  rst_in,         // synchronous reset
  input wire css_host_t             host_in,        // host bus pins
  input wire logic                  adc_conv_out,   // convert pulse
  input wire logic                  adc_sclk_out,   // receive bit clock
  input wire logic [AUX_SEL_W-1:0]  aux_sel_out,    // aux selector
  input wire logic                  sample_vld_out, // samples new
  input wire logic                  tx_sclk_out,    // transmit bit clock
  input wire logic                  tx_frame_out,   // transmit framing
  input wire logic                  p2s_sclk_out,   // p2s bit clock
  input wire logic                  p2s_frame_out,  // p2s framing
  input wire logic [SLOW_SEL_W-1:0] slow_sel_out,   // slow selector
  input wire logic                  buf_en_out,     // host buffers on
  input wire logic [CS_W-1:0]       cs_out,         // chip selects
  input wire logic [SAMPLE_W-1:0]   cfg0_out,       // config latch 0
  input wire logic [SAMPLE_W-1:0]   iso_data_out,   // analog bus data
  input wire logic                  iso_oe_out,     // analog bus drive
  input wire logic [1:0]            iso_stb_out     // analog strobes
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic [9:0] gap;
  logic       seen;
  logic [9:0] fcnt;

  // clocks since the last convert pulse
  always_ff @(posedge clk_in) begin
    if (rst_in || adc_conv_out) begin
      gap <= 10'h001;
    end else if (gap != 10'h3ff) begin
      gap <= gap + 10'h001;
    end
  end

  // first convert pulse seen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seen <= 1'b0;
    end else if (adc_conv_out) begin
      seen <= 1'b1;
    end
  end

  // length of the transmit frame
  always_ff @(posedge clk_in) begin
    if (rst_in || !tx_frame_out) begin
      fcnt <= 10'h000;
    end else begin
      fcnt <= fcnt + 10'h001;
    end
  end

  property p_conv_period;
    adc_conv_out && seen |-> gap == 10'h320;
  endproperty
  a_conv_period: assert property (p_conv_period) else $error("convert spacing wrong");

  property p_vld_place;
    sample_vld_out |-> seen && gap > 10'h258 && gap < 10'h2d0;
  endproperty
  a_vld_place: assert property (p_vld_place) else $error("sample valid misplaced");

  property p_aux_step;
    $changed(aux_sel_out) |-> aux_sel_out == $past(aux_sel_out) + 2'h1;
  endproperty
  a_aux_step: assert property (p_aux_step) else $error("aux selector step wrong");

  property p_slow_step;
    $changed(slow_sel_out) |-> slow_sel_out == $past(slow_sel_out) + 3'h1;
  endproperty
  a_slow_step: assert property (p_slow_step) else $error("slow selector step wrong");

  property p_rx_bit;
    $rose(adc_sclk_out) |-> ##19 adc_sclk_out ##1 !adc_sclk_out;
  endproperty
  a_rx_bit: assert property (p_rx_bit) else $error("receive clock high time wrong");

  property p_tx_bit;
    $rose(tx_sclk_out) |-> tx_sclk_out[*8] ##1 tx_sclk_out[*2] ##1 !tx_sclk_out;
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("transmit clock high time wrong");

  property p_p2s_same;
    p2s_sclk_out == tx_sclk_out && p2s_frame_out == tx_frame_out;
  endproperty
  a_p2s_same: assert property (p_p2s_same) else $error("p2s timing differs");

  property p_frame_len;
    $fell(tx_frame_out) |-> fcnt == 10'h280;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("transmit frame length wrong");

  property p_buf_off;
    $rose(host_in.cs_n) |-> ##[1:5] !buf_en_out;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffers stay on");

  property p_cs_map;
    cs_out == (buf_en_out ? 8'h01 << $past(host_in.addr, 2) : 8'h00);
  endproperty
  a_cs_map: assert property (p_cs_map) else $error("chip select wrong");

  property p_iso_drive;
    iso_oe_out == (cs_out[5:4] != 2'h0) && (iso_oe_out || iso_data_out == 16'h0000);
  endproperty
  a_iso_drive: assert property (p_iso_drive) else $error("analog bus drive wrong");

  property p_iso_stb;
    $rose(iso_oe_out) |-> iso_stb_out == cs_out[5:4] ##1 iso_stb_out == 2'h0;
  endproperty
  a_iso_stb: assert property (p_iso_stb) else $error("analog strobe wrong");

  property p_cfg_hold;
    $changed(cfg0_out) |-> cs_out[0];
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");
endmodule // css_sched_monitor

bind css_sched css_sched_monitor i_css_sched_monitor (.clk_in(clk_in), .rst_in(rst_in), .host_in(host_in),
  .adc_conv_out(adc_conv_out), .adc_sclk_out(adc_sclk_out), .aux_sel_out(aux_sel_out),
  .sample_vld_out(sample_vld_out), .tx_sclk_out(tx_sclk_out), .tx_frame_out(tx_frame_out),
  .p2s_sclk_out(p2s_sclk_out), .p2s_frame_out(p2s_frame_out), .slow_sel_out(slow_sel_out),
  .buf_en_out(buf_en_out), .cs_out(cs_out), .cfg0_out(cfg0_out), .iso_data_out(iso_data_out),
  .iso_oe_out(iso_oe_out), .iso_stb_out(iso_stb_out));

// File: verif/css_conv_model.sv
// converter model: dual input converter and output word capture
`timescale 1ns/10ps
module css_conv_model
  import css_pkg::*;
(
  input  wire logic                 clk_in,       // system clock
  input  wire logic                 rst_in,       // reset
  input  wire logic                 conv_in,      // convert pulse
  input  wire logic                 sclk_in,      // receive bit clock
  input  wire logic [AUX_SEL_W-1:0] aux_sel_in,   // aux input chosen
  input  wire logic                 tx_sclk_in,   // transmit bit clock
  input  wire logic                 tx_data_in,   // transmit data
  input  wire logic                 tx_frame_in,  // transmit framing
  input  wire logic                 p2s_data_in,  // p2s data
  output logic                      sig_out,      // signal serial data
  output logic                      aux_out,      // aux serial data
  output logic [31:0]               tx_word_out,  // last transmit word
  output logic [31:0]               p2s_word_out, // last p2s word
  output logic                      word_out      // word complete pulse
);
  logic [15:0] sig_sh, aux_sh;
  logic [7:0]  frames;
  logic        rx_q, tx_q, fr_q;
  logic [31:0] tx_sh, p2s_sh;

  // both channels sampled together once per cycle, msb first on rising clock
  always @(posedge clk_in) begin
    rx_q <= sclk_in;
    if (rst_in) begin
      {sig_out, aux_out, frames} <= 10'h000;
    end else if (conv_in) begin
      sig_sh <= {8'h96, frames};
      aux_sh <= {14'h1a5c, aux_sel_in};
      frames <= frames + 8'h01;
      sig_out <= ~sig_out;
      aux_out <= ~aux_out;
    end else if (sclk_in && !rx_q) begin
      sig_out <= sig_sh[15];
      aux_out <= aux_sh[15];
      sig_sh <= {sig_sh[14:0], ~sig_sh[15]};
      aux_sh <= {aux_sh[14:0], ~aux_sh[15]};
    end
  end

  // output converters take a bit on the falling clock
  always @(posedge clk_in) begin
    tx_q <= tx_sclk_in;
    fr_q <= tx_frame_in;
    word_out <= 1'b0;
    if (tx_q && !tx_sclk_in) begin
      tx_sh <= {tx_sh[30:0], tx_data_in};
      p2s_sh <= {p2s_sh[30:0], p2s_data_in};
    end
    if (fr_q && !tx_frame_in) begin
      tx_word_out <= tx_sh;
      p2s_word_out <= p2s_sh;
      word_out <= 1'b1;
    end
  end
endmodule // css_conv_model

// File: verif/css_sched_test.sv
// self-checking bench for the converter sample scheduler
`timescale 1ns/10ps
module css_sched_test;
  import css_pkg::*;
  logic                  clk_in, rst_in, adc_sig_in, adc_aux_in, word_done;
  css_host_t             host_in;
  css_iq_t               iq_in;
  logic [SAMPLE_W-1:0]   slow_val_in [SLOW_OUTS];
  logic [SAMPLE_W-1:0]   sig_sample_out, aux_sample_out, sine_out, cfg0_out, cfg1_out, iso_data_out;
  logic [AUX_SEL_W-1:0]  aux_sel_out, aux_tag_out;
  logic [SLOW_SEL_W-1:0] slow_sel_out;
  logic [CS_W-1:0]       cs_out;
  logic [1:0]            iso_stb_out;
  logic                  adc_conv_out, adc_sclk_out, sample_vld_out, tx_sclk_out, tx_data_out, tx_frame_out;
  logic                  p2s_sclk_out, p2s_data_out, p2s_frame_out, instr_tick_out, buf_en_out, iso_oe_out;
  logic [31:0]           tx_word, p2s_word;
  int                    err_count, cmp_count;

  css_sched i_css_sched (.clk_in(clk_in), .rst_in(rst_in), .host_in(host_in), .adc_sig_in(adc_sig_in),
    .adc_aux_in(adc_aux_in), .iq_in(iq_in), .slow_val_in(slow_val_in), .adc_conv_out(adc_conv_out),
    .adc_sclk_out(adc_sclk_out), .aux_sel_out(aux_sel_out), .sig_sample_out(sig_sample_out),
    .aux_sample_out(aux_sample_out), .aux_tag_out(aux_tag_out), .sample_vld_out(sample_vld_out),
    .tx_sclk_out(tx_sclk_out), .tx_data_out(tx_data_out), .tx_frame_out(tx_frame_out),
    .p2s_sclk_out(p2s_sclk_out), .p2s_data_out(p2s_data_out), .p2s_frame_out(p2s_frame_out),
    .slow_sel_out(slow_sel_out), .sine_out(sine_out), .instr_tick_out(instr_tick_out),
    .buf_en_out(buf_en_out), .cs_out(cs_out), .cfg0_out(cfg0_out), .cfg1_out(cfg1_out),
    .iso_data_out(iso_data_out), .iso_oe_out(iso_oe_out), .iso_stb_out(iso_stb_out));

  css_conv_model i_css_conv_model (.clk_in(clk_in), .rst_in(rst_in), .conv_in(adc_conv_out),
    .sclk_in(adc_sclk_out), .aux_sel_in(aux_sel_out), .tx_sclk_in(tx_sclk_out), .tx_data_in(tx_data_out),
    .tx_frame_in(tx_frame_out), .p2s_data_in(p2s_data_out), .sig_out(adc_sig_in), .aux_out(adc_aux_in),
    .tx_word_out(tx_word), .p2s_word_out(p2s_word), .word_out(word_done));

  // free-running 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bounded wait for sample valid (0) or a captured output word (1)
  task automatic wait_for(input bit which);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while ((which ? word_done : sample_vld_out) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      check("wait_bound", 32'h1, 32'h0);
      stop_test();
    end
  endtask

  // one host write held six clocks, checked while held and after release
  task automatic host_wr(input logic [ADDR_W-1:0] a, input logic [SAMPLE_W-1:0] d);
    @(posedge clk_in);
    host_in <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: d};
    repeat (5) @(posedge clk_in);
    #1;
    check("buf_on", buf_en_out, 1'b1);
    check("cs_map", cs_out, (a < 4'h8) ? 8'h01 << a[2:0] : 8'h00);
    check("iso_oe", iso_oe_out, a == 4'h4 || a == 4'h5);
    check("iso_data", iso_data_out, (a == ADDR_ANA0 || a == ADDR_ANA1) ? d : 16'h0000);
    @(posedge clk_in);
    host_in.cs_n <= 1'b1;
    host_in.wr_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    check("buf_off", buf_en_out, 1'b0);
    check("iso_idle", iso_oe_out, 1'b0);
  endtask

  task automatic t_host();
    host_wr(ADDR_CFG0, 16'h1234);
    host_wr(ADDR_CFG1, 16'h5678);
    host_wr(ADDR_ANA0, 16'h0f0f);
    host_wr(ADDR_ANA1, 16'hf0f0);
    host_wr(4'h6, 16'hffff);
    host_wr(4'h9, 16'hffff);
    check("cfg0", cfg0_out, 16'h1234);
    check("cfg1", cfg1_out, 16'h5678);
    $display("host test done");
  endtask

  task automatic t_stream();
    logic [7:0] low;
    logic [1:0] tag;
    int         n;
    wait_for(1'b0);
    low = sig_sample_out[7:0];
    tag = aux_tag_out;
    repeat (6) begin
      wait_for(1'b0);
      low++;
      tag++;
      check("sig_word", sig_sample_out, {8'h96, low});
      check("aux_tag", aux_tag_out, tag);
      check("aux_word", aux_sample_out, {14'h1a5c, tag});
    end
    // instruction slots over one whole cycle
    n = 0;
    repeat (CYCLE_CLKS) begin
      @(posedge clk_in);
      #1;
      if (instr_tick_out === 1'b1) begin
        n++;
      end
    end
    check("instr_ticks", n, INSTR_PER_CYCLE);
    $display("stream test done");
  endtask

  task automatic t_out();
    logic [7:0]  slots;
    logic [15:0] last_sine;
    slots = 8'h00;
    host_wr(ADDR_FREQ_LO, 16'h0000);
    host_wr(ADDR_FREQ_HI, 16'h0400);
    wait_for(1'b1);
    repeat (SLOW_OUTS) begin
      last_sine = sine_out;
      wait_for(1'b1);
      check("x_word", tx_word[15:0], iq_in.x);
      check("sine_word", tx_word[31:16], last_sine);
      check("y_word", p2s_word[31:16], iq_in.y);
      check("slot_word", p2s_word[15:3], 13'h1e6b);
      check("sine_step", sine_out != last_sine, 1'b1);
      slots[p2s_word[2:0]] = 1'b1;
    end
    check("slots", slots, 8'hff);
    $display("output test done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_in = 1'b1;
    host_in = '{cs_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 16'h0000};
    iq_in = '{x: 16'h3c5a, y: 16'hc3a5};
    for (int i = 0; i < SLOW_OUTS; i++) begin
      slow_val_in[i] = {13'h1e6b, 3'(i)};
    end
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_host();
    t_stream();
    t_out();
    stop_test();
  end
endmodule // css_sched_test
